//--- shared/sflash_pkg.sv
// Shared constants and types for the serial flash command and read front end
package sflash_pkg;

  // Opcodes
  localparam logic [7:0] OP_READ_FAST = 8'h0b;
  localparam logic [7:0] OP_READ_SLOW = 8'h03;
  localparam logic [7:0] OP_READ_DUAL = 8'h3b;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OP_BLK4_ERASE = 8'h20;
  localparam logic [7:0] OP_BLK32_ERASE_A = 8'h52;
  localparam logic [7:0] OP_BLK32_ERASE_B = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_C = 8'h62;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_OTP_PROGRAM = 8'h9b;
  localparam logic [7:0] OP_OTP_READ = 8'h77;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE1 = 8'h01;
  localparam logic [7:0] OP_STATUS_WRITE2 = 8'h31;
  localparam logic [7:0] OP_ID_READ = 8'h9f;
  localparam logic [7:0] OP_ID_READ_OLD = 8'h15;
  localparam logic [7:0] OP_DEEP_DOWN = 8'hb9;
  localparam logic [7:0] OP_DEEP_RESUME = 8'hab;
  localparam logic [7:0] OP_ULTRA_DOWN = 8'h79;

  // Array geometry
  localparam int ADDR_BITS = 15;
  localparam logic [14:0] ARRAY_LAST = 15'h7fff;
  localparam logic [14:0] ARRAY_FIRST = 15'h0000;

  // Field layout of the 24-bit address
  localparam int ADDR_BYTES = 3;
  localparam int FAST_DUMMY_BYTES = 1;
  localparam int OTP_DUMMY_BYTES = 2;

  // Host clock limits, in MHz
  localparam int FAST_READ_MHZ = 104;
  localparam int SLOW_READ_CLOCK_LIMIT_MHZ = 33;
  localparam int DUAL_READ_CLOCK_LIMIT_MHZ = 50;

  // Command classes seen by the engine behind this front end
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_READ = 4'h1,
    CMD_READ_DUAL = 4'h2,
    CMD_PROGRAM = 4'h3,
    CMD_PAGE_ERASE = 4'h4,
    CMD_BLK4_ERASE = 4'h5,
    CMD_BLK32_ERASE = 4'h6,
    CMD_CHIP_ERASE = 4'h7,
    CMD_OTP_READ = 4'h8,
    CMD_OTP_PROGRAM = 4'h9,
    CMD_STATUS_READ = 4'ha,
    CMD_STATUS_WRITE = 4'hb,
    CMD_ID_READ = 4'hc,
    CMD_POWER = 4'hd
  } cmd_class_t;

  // Decoded command shape
  typedef struct packed {
    logic known;
    cmd_class_t cls;
    logic [1:0] addr_bytes;
    logic [1:0] dummy_bytes;
    logic is_read;
    logic dual;
  } cmd_info_t;

  // Completed command handed to the engine
  typedef struct packed {
    cmd_class_t cls;
    logic [7:0] opcode;
    logic [14:0] addr;
  } cmd_report_t;

  // Memory fetch request
  typedef struct packed {
    logic [14:0] addr;
  } fetch_req_t;

endpackage

//--- rtl/sflash_decode.sv
// Opcode decoder: command class and byte counts for each opcode
`timescale 1ns/10ps
module sflash_decode (
  // Opcode in
  input wire logic [7:0] opcode,
  // Shape out
  output sflash_pkg::cmd_info_t info
);

  // Table of supported opcodes
  always_comb begin
    info = '0;
    info.known = 1'b1;
    info.cls = sflash_pkg::CMD_NONE;
    unique case (opcode)
      sflash_pkg::OP_READ_FAST: begin // [R7]
        info.cls = sflash_pkg::CMD_READ;
        info.addr_bytes = 2'(sflash_pkg::ADDR_BYTES);
        info.dummy_bytes = 2'(sflash_pkg::FAST_DUMMY_BYTES);
        info.is_read = 1'b1;
      end
      sflash_pkg::OP_READ_SLOW: begin // [R7]
        info.cls = sflash_pkg::CMD_READ;
        info.addr_bytes = 2'(sflash_pkg::ADDR_BYTES);
        info.is_read = 1'b1;
      end
      sflash_pkg::OP_READ_DUAL: begin // [R9]
        info.cls = sflash_pkg::CMD_READ_DUAL;
        info.addr_bytes = 2'(sflash_pkg::ADDR_BYTES);
        info.dummy_bytes = 2'(sflash_pkg::FAST_DUMMY_BYTES);
        info.is_read = 1'b1;
        info.dual = 1'b1;
      end
      sflash_pkg::OP_PROGRAM: begin // [R15]
        info.cls = sflash_pkg::CMD_PROGRAM;
        info.addr_bytes = 2'(sflash_pkg::ADDR_BYTES);
      end
      sflash_pkg::OP_PAGE_ERASE: begin // [R15]
        info.cls = sflash_pkg::CMD_PAGE_ERASE;
        info.addr_bytes = 2'(sflash_pkg::ADDR_BYTES);
      end
      sflash_pkg::OP_BLK4_ERASE: begin // [R15]
        info.cls = sflash_pkg::CMD_BLK4_ERASE;
        info.addr_bytes = 2'(sflash_pkg::ADDR_BYTES);
      end
      sflash_pkg::OP_BLK32_ERASE_A, sflash_pkg::OP_BLK32_ERASE_B: begin // [R15]
        info.cls = sflash_pkg::CMD_BLK32_ERASE;
        info.addr_bytes = 2'(sflash_pkg::ADDR_BYTES);
      end
      sflash_pkg::OP_CHIP_ERASE_A, sflash_pkg::OP_CHIP_ERASE_B,
      sflash_pkg::OP_CHIP_ERASE_C: begin // [R16]
        info.cls = sflash_pkg::CMD_CHIP_ERASE;
      end
      sflash_pkg::OP_OTP_READ: begin // [R17]
        info.cls = sflash_pkg::CMD_OTP_READ;
        info.addr_bytes = 2'(sflash_pkg::ADDR_BYTES);
        info.dummy_bytes = 2'(sflash_pkg::OTP_DUMMY_BYTES);
      end
      sflash_pkg::OP_OTP_PROGRAM: begin // [R17]
        info.cls = sflash_pkg::CMD_OTP_PROGRAM;
        info.addr_bytes = 2'(sflash_pkg::ADDR_BYTES);
      end
      sflash_pkg::OP_STATUS_READ: begin // [R18]
        info.cls = sflash_pkg::CMD_STATUS_READ;
      end
      sflash_pkg::OP_STATUS_WRITE1, sflash_pkg::OP_STATUS_WRITE2: begin // [R18]
        info.cls = sflash_pkg::CMD_STATUS_WRITE;
      end
      sflash_pkg::OP_ID_READ, sflash_pkg::OP_ID_READ_OLD: begin // [R19]
        info.cls = sflash_pkg::CMD_ID_READ;
      end
      sflash_pkg::OP_DEEP_DOWN, sflash_pkg::OP_DEEP_RESUME,
      sflash_pkg::OP_ULTRA_DOWN: begin // [R20]
        info.cls = sflash_pkg::CMD_POWER;
      end
      default: begin
        info.known = 1'b0; // [R4]
      end
    endcase
  end

endmodule

//--- rtl/sflash_skid.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module sflash_skid #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Flush of stale entries
  input wire logic flush,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ff;
  logic [PW-1:0] rd_ff;
  logic [PW:0] cnt_ff;
  logic push;
  logic pop;

  // Handshake terms
  assign in_ready = (cnt_ff != (PW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers and occupancy
  always_ff @(posedge ref_clk) begin
    if (!resetn || flush) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wr_ff <= (wr_ff == PW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
      if (pop) rd_ff <= (rd_ff == PW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
      cnt_ff <= cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Storage
  always_ff @(posedge ref_clk) begin
    if (push) mem_ff[wr_ff] <= in_data;
  end

endmodule

//--- rtl/sflash_front.sv
// Serial port front end: framing, opcode decode and array read streaming
//
// What this block does
// R1: Mode 0 or 3 only; input sampled on rising, output launched on falling clock.
// R2: Host lowers select, sends 8-bit opcode, then arguments, then raises select.
// R3: All opcode, address and data bytes travel most significant bit first.
// R4: Unknown opcode starts nothing; input ignored until select is cycled.
// R5: Select rising before opcode and address complete performs nothing, back to idle.
// R6: Address is 24 bits; bits 23 to 15 are ignored, top is 007fff.
// R7: 0b takes three address bytes and one dummy; 03 takes address only.
// R8: Host uses 0b up to 104 MHz, 03 only up to 33 MHz.
// R9: Dual read 3b takes address and one dummy; host clock at most 50 MHz.
// R10: Address counter starts at given address, advances per byte shifted out.
// R11: After last array byte counter wraps to zero with no gap.
// R12: Select rising ends single read at once, output line floated.
// R13: Dual read sends two bits per falling edge, high on output line.
// R14: Select rising during dual read floats both data lines.
// R15: Decode 02, 81, 20, 52 and d8, each with three address bytes.
// R16: Decode 60, c7 and 62 as chip erase with no arguments.
// R17: Decode otp read 77 and otp program 9b.
// R18: Decode status read 05 and status writes 01 and 31.
// R19: Decode identification reads 9f and 15.
// R20: Decode power commands b9, ab and 79 as bare opcodes.
// R21: With select high, input ignored and output floated.
// R22: Data lines are driven only once the output data phase begins.
`timescale 1ns/10ps
module sflash_front #(
  parameter int ADDR_W = sflash_pkg::ADDR_BITS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Serial pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si_in,
  output logic si_out,
  output logic si_oe,
  output logic so_out,
  output logic so_oe,
  // Array fetch port
  output logic fetch_valid,
  output sflash_pkg::fetch_req_t fetch_req,
  input wire logic fetch_ready,
  input wire logic data_valid,
  input wire logic [7:0] data_byte,
  output logic data_ready,
  // Command report to the engine
  output logic cmd_valid,
  output sflash_pkg::cmd_report_t cmd_report,
  output logic cmd_abort
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPCODE = 3'b001,
    ST_ADDR = 3'b010,
    ST_DUMMY = 3'b011,
    ST_DATA = 3'b100,
    ST_ARGS = 3'b101,
    ST_IGNORE = 3'b110
  } state_t;

  // Pin synchronisers
  logic [1:0] sck_sync_ff;
  logic [1:0] cs_sync_ff;
  logic [1:0] si_sync_ff;
  logic sck_prev_ff;
  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic rise;
  logic fall;

  state_t state_ff;
  state_t nxt_state;
  logic [2:0] bit_ff;
  logic [1:0] byte_ff;
  logic [7:0] shift_ff;
  logic [7:0] opcode_ff;
  logic [23:0] addr_in_ff;
  logic [ADDR_W-1:0] rd_addr_ff;
  logic [7:0] out_sh_ff;
  logic [2:0] out_bit_ff;
  logic dual_ff;
  logic out_loaded_ff;
  sflash_pkg::cmd_info_t info_ff;
  sflash_pkg::cmd_info_t dec_info;
  logic byte_done;
  logic [7:0] byte_val;
  logic last_arg;
  logic deselect;
  logic fetch_push;
  logic fetch_pending_ff;
  logic buf_valid;
  logic [7:0] buf_data;
  logic buf_take;
  logic buf_in_ready;
  logic [ADDR_W-1:0] addr_next;

  // Two flops on every pin
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sck_sync_ff <= 2'h0;
      cs_sync_ff <= 2'h3;
      si_sync_ff <= 2'h0;
      sck_prev_ff <= 1'b0;
    end else begin
      sck_sync_ff <= {sck_sync_ff[0], sck};
      cs_sync_ff <= {cs_sync_ff[0], cs_n};
      si_sync_ff <= {si_sync_ff[0], si_in};
      sck_prev_ff <= sck_sync_ff[1];
    end
  end

  // Clock edges found after synchronising
  assign sck_s = sck_sync_ff[1];
  assign cs_n_s = cs_sync_ff[1];
  assign si_s = si_sync_ff[1];
  assign rise = sck_s && !sck_prev_ff && !cs_n_s; // [R1] [R21]
  assign fall = !sck_s && sck_prev_ff && !cs_n_s; // [R1]
  assign deselect = cs_n_s;

  // Opcode table
  sflash_decode u_decode (
    .opcode(byte_val),
    .info(dec_info)
  );

  // Byte assembly, most significant bit first
  assign byte_val = {shift_ff[6:0], si_s}; // [R3]
  assign byte_done = rise && (bit_ff == 3'h7);
  assign last_arg = (byte_ff == 2'h0);
  assign addr_next = (rd_addr_ff == sflash_pkg::ARRAY_LAST) ?
                     sflash_pkg::ARRAY_FIRST : rd_addr_ff + 1'b1; // [R11]

  // Phase sequencing
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (!deselect) nxt_state = ST_OPCODE; // [R2]
      end
      ST_OPCODE: begin
        if (byte_done) begin
          if (!dec_info.known) nxt_state = ST_IGNORE; // [R4]
          else if (dec_info.addr_bytes != 2'h0) nxt_state = ST_ADDR;
          else if (dec_info.dummy_bytes != 2'h0) nxt_state = ST_DUMMY;
          else nxt_state = ST_ARGS;
        end
      end
      ST_ADDR: begin
        if (byte_done && last_arg) begin
          if (info_ff.dummy_bytes != 2'h0) nxt_state = ST_DUMMY;
          else if (info_ff.is_read) nxt_state = ST_DATA;
          else nxt_state = ST_ARGS;
        end
      end
      ST_DUMMY: begin
        if (byte_done && last_arg) begin
          nxt_state = info_ff.is_read ? ST_DATA : ST_ARGS;
        end
      end
      ST_DATA, ST_ARGS, ST_IGNORE: begin
        nxt_state = state_ff;
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (deselect) nxt_state = ST_IDLE; // [R5] [R12] [R14] [R21]
  end

  // State, counters and captured fields
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
      bit_ff <= 3'h0;
      byte_ff <= 2'h0;
      shift_ff <= 8'h00;
      opcode_ff <= 8'h00;
      addr_in_ff <= 24'h000000;
      info_ff <= '0;
      dual_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (deselect) begin
        bit_ff <= 3'h0;
      end else if (rise) begin
        bit_ff <= bit_ff + 3'h1;
        shift_ff <= byte_val;
      end
      if (byte_done && state_ff == ST_OPCODE) begin
        opcode_ff <= byte_val;
        info_ff <= dec_info;
        dual_ff <= dec_info.dual;
        byte_ff <= (dec_info.addr_bytes != 2'h0) ? dec_info.addr_bytes - 2'h1
                   : dec_info.dummy_bytes - 2'h1;
      end else if (byte_done && state_ff == ST_ADDR) begin
        addr_in_ff <= {addr_in_ff[15:0], byte_val}; // [R6]
        byte_ff <= last_arg ? info_ff.dummy_bytes - 2'h1 : byte_ff - 2'h1;
      end else if (byte_done && state_ff == ST_DUMMY) begin
        byte_ff <= byte_ff - 2'h1;
      end
    end
  end

  // Fetch of array bytes into the two-entry buffer
  assign fetch_push = fetch_valid && fetch_ready;
  assign data_ready = buf_in_ready;

  sflash_skid #(
    .WIDTH(8),
    .DEPTH(2)
  ) u_buf (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .flush(state_ff != ST_DATA),
    .in_valid(data_valid && state_ff == ST_DATA),
    .in_ready(buf_in_ready),
    .in_data(data_byte),
    .out_valid(buf_valid),
    .out_ready(buf_take),
    .out_data(buf_data)
  );

  // Next byte taken when the previous one has fully left
  assign buf_take = buf_valid && (!out_loaded_ff ||
                    (fall && (dual_ff ? out_bit_ff == 3'h6 : out_bit_ff == 3'h7)));

  // Address counter and fetch request
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rd_addr_ff <= '0;
      fetch_valid <= 1'b0;
      fetch_req <= '0;
      fetch_pending_ff <= 1'b0;
    end else if (state_ff != ST_DATA) begin
      rd_addr_ff <= addr_in_ff[ADDR_W-1:0]; // [R6] [R10]
      fetch_valid <= 1'b0;
      fetch_pending_ff <= 1'b0;
      // Slow read only: the last address byte is still in flight on this edge
      if (nxt_state == ST_DATA && state_ff == ST_ADDR) begin
        rd_addr_ff <= {addr_in_ff[ADDR_W-9:0], byte_val}; // [R6]
      end
    end else begin
      if (fetch_push) fetch_valid <= 1'b0;
      if (!fetch_valid && !fetch_pending_ff) begin
        fetch_valid <= 1'b1;
        fetch_req.addr <= rd_addr_ff;
        fetch_pending_ff <= 1'b1;
      end
      if (fetch_push) begin
        rd_addr_ff <= addr_next; // [R10] [R11]
      end
      if (data_valid && buf_in_ready) fetch_pending_ff <= 1'b0;
    end
  end

  // Output shifter and pin drivers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      out_sh_ff <= 8'h00;
      out_bit_ff <= 3'h0;
      out_loaded_ff <= 1'b0;
      so_out <= 1'b0;
      si_out <= 1'b0;
      so_oe <= 1'b0;
      si_oe <= 1'b0;
    end else if (state_ff != ST_DATA || deselect) begin
      out_loaded_ff <= 1'b0;
      out_bit_ff <= 3'h0;
      so_oe <= 1'b0; // [R12] [R21] [R22]
      si_oe <= 1'b0; // [R14] [R22]
    end else begin
      if (buf_take) begin
        out_sh_ff <= buf_data;
        out_bit_ff <= 3'h0;
        out_loaded_ff <= 1'b1;
      end
      if (fall && out_loaded_ff) begin
        so_oe <= 1'b1;
        si_oe <= dual_ff; // [R13]
        if (dual_ff) begin
          so_out <= out_sh_ff[3'h7 - out_bit_ff]; // [R13]
          si_out <= out_sh_ff[3'h6 - out_bit_ff]; // [R13]
          if (!buf_take) out_bit_ff <= out_bit_ff + 3'h2;
        end else begin
          so_out <= out_sh_ff[3'h7 - out_bit_ff]; // [R3]
          if (!buf_take) out_bit_ff <= out_bit_ff + 3'h1;
        end
      end
    end
  end

  // Report of each completed command frame
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cmd_valid <= 1'b0;
      cmd_abort <= 1'b0;
      cmd_report <= '0;
    end else begin
      cmd_valid <= 1'b0;
      cmd_abort <= 1'b0;
      if (deselect && state_ff != ST_IDLE) begin
        cmd_report.cls <= info_ff.cls;
        cmd_report.opcode <= opcode_ff;
        cmd_report.addr <= addr_in_ff[ADDR_W-1:0];
        if (state_ff == ST_ARGS || state_ff == ST_DATA) begin
          cmd_valid <= 1'b1;
        end else begin
          cmd_abort <= (state_ff != ST_IGNORE); // [R5]
        end
      end
    end
  end

endmodule

//--- verif/sflash_front_properties.sv
// Concurrent checks on the serial front end ports
`timescale 1ns/10ps
module sflash_front_checker #(
  parameter int ADDR_W = 15
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Serial pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si_out,
  input wire logic si_oe,
  input wire logic so_out,
  input wire logic so_oe,
  // Array and engine side
  input wire logic fetch_valid,
  input wire sflash_pkg::fetch_req_t fetch_req,
  input wire logic fetch_ready,
  input wire logic cmd_valid,
  input wire logic cmd_abort
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // Pin behaviour around select and clock edges
  lines_float_a: assert property (cs_n [*4] |-> !so_oe && !si_oe)
    else $error("data line driven while deselected");
  dual_pair_a: assert property (si_oe |-> so_oe)
    else $error("second line driven without output line");
  drive_start_a: assert property ($rose(so_oe) |-> !sck && !cs_n)
    else $error("output enabled outside low clock phase");
  so_launch_a: assert property (so_oe && $past(so_oe) && $changed(so_out) |-> !sck)
    else $error("output bit changed while clock high");
  si_launch_a: assert property (si_oe && $past(si_oe) && $changed(si_out) |-> !sck)
    else $error("second line bit changed while clock high");
  drive_hold_a: assert property (so_oe && !cs_n |=> so_oe)
    else $error("output released while selected");

  // Array fetch and engine report
  fetch_hold_a: assert property (fetch_valid && !fetch_ready && !cs_n
    |=> fetch_valid && $stable(fetch_req))
    else $error("fetch request dropped or changed before acceptance");
  pulse_once_a: assert property (cmd_valid |=> !cmd_valid)
    else $error("command report longer than one cycle");
  end_kind_a: assert property (cmd_valid || cmd_abort |-> cs_n && !(cmd_valid && cmd_abort))
    else $error("frame end report while selected or doubled");

  // Main scenarios reached
  cover property (cmd_valid);
  cover property (cmd_abort);
  cover property ($rose(si_oe));
  cover property (fetch_valid && fetch_ready);
endmodule

//--- verif/sflash_host_model.sv
// SPI host model: frames commands in mode 0 or 3 and collects read bytes
`timescale 1ns/10ps
module sflash_host_model (
  // Clock
  input wire logic ref_clk,
  // Idle clock level: low for mode 0, high for mode 3
  input wire logic park_hi,
  // Serial pins
  output logic sck,
  output logic cs_n,
  output logic si_drv,
  output logic si_en,
  input wire logic so_line,
  input wire logic si_line
);
  logic [7:0] rx_q[$];
  // Idle bus: select high, clock parked low
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si_drv = 1'b0;
    si_en = 1'b1;
  end
  // Half of an 80 ns clock, below every read rate limit
  task automatic half();
    repeat (8) @(posedge ref_clk);
  endtask
  // One clock: set up while low, sample just before the rise
  task automatic tick(input logic b, output logic so_s, output logic si_s);
    si_drv <= b;
    half();
    so_s = so_line;
    si_s = si_line;
    sck <= 1'b1;
    half();
    sck <= 1'b0;
  endtask
  // Opcode, address, dummy, data clocks, then select raised
  task automatic frame(input logic [7:0] op, input logic [23:0] adr, input int nadr,
      input int ndum, input int nclk, input bit dual);
    logic [31:0] hdr;
    logic [7:0] sh;
    logic a;
    logic b;
    int k;
    int nb;
    hdr = {op, adr};
    nb = 0;
    sh = 8'h00;
    rx_q.delete();
    cs_n <= 1'b0;
    sck <= 1'b0;
    for (k = 0; k < 8 + 8 * (nadr + ndum); k++) begin
      tick(k < 8 + 8 * nadr ? hdr[31 - k] : adr[k % 8], a, b);
    end
    si_en <= !dual;
    for (k = 0; k < nclk; k++) begin
      tick(~si_drv, a, b);
      sh = dual ? {sh[5:0], a, b} : {sh[6:0], a};
      nb = nb + (dual ? 2 : 1);
      if (nb % 8 == 0) begin
        rx_q.push_back(sh);
      end
    end
    half();
    cs_n <= 1'b1;
    si_en <= 1'b1;
    half();
    sck <= park_hi;
    half();
  endtask
endmodule

//--- verif/tb_top.sv
// Testbench for the serial front end with host and array models
`timescale 1ns/10ps
module tb_top;
  logic ref_clk, resetn, sck, cs_n, host_si, host_en, si_wire, so_line;
  logic si_out, si_oe, so_out, so_oe, fetch_valid, data_ready;
  logic fetch_ready = 1'b0;
  logic data_valid = 1'b0;
  logic park_hi = 1'b0;
  logic cmd_valid, cmd_abort;
  logic [7:0] data_byte = 8'h00;
  sflash_pkg::fetch_req_t fetch_req;
  sflash_pkg::cmd_report_t cmd_report, last_rep;
  logic [7:0] mem_q[$];
  int seed = 32'h0a9b9b92;
  int err_total = 0;
  int tests_run = 0;
  int n_valid = 0;
  int n_abort = 0;
  int n_drive = 0;
  int cycles = 0;
  int i;
  int k;
  logic [7:0] op_tab [18] = '{8'h81, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h62, 8'h02, 8'h9b,
    8'h77, 8'h05, 8'h01, 8'h31, 8'h9f, 8'h15, 8'hb9, 8'hab, 8'h79};
  logic [3:0] cls_tab [18] = '{4'h4, 4'h5, 4'h6, 4'h6, 4'h7, 4'h7, 4'h7, 4'h3, 4'h9,
    4'h8, 4'ha, 4'hb, 4'hb, 4'hc, 4'hc, 4'hd, 4'hd, 4'hd};

  // 200 MHz reference clock
  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;

  // Shared lines: device drive wins, a released line shows the inverse
  assign si_wire = si_oe ? si_out : (host_en ? host_si : ~host_si);
  assign so_line = so_oe ? so_out : ~so_out;

  sflash_host_model host (.ref_clk(ref_clk), .park_hi(park_hi), .sck(sck), .cs_n(cs_n),
    .si_drv(host_si),
    .si_en(host_en), .so_line(so_line), .si_line(si_wire));

  sflash_front uut (.ref_clk(ref_clk), .resetn(resetn), .sck(sck), .cs_n(cs_n),
    .si_in(si_wire), .si_out(si_out), .si_oe(si_oe), .so_out(so_out), .so_oe(so_oe),
    .fetch_valid(fetch_valid), .fetch_req(fetch_req), .fetch_ready(fetch_ready),
    .data_valid(data_valid), .data_byte(data_byte), .data_ready(data_ready),
    .cmd_valid(cmd_valid), .cmd_report(cmd_report), .cmd_abort(cmd_abort));

  // Array contents as seen by the bench
  function automatic logic [7:0] mem_val(input logic [14:0] a);
    return a[7:0] ^ {a[14:8], 1'b1};
  endfunction

  // Array model: random acceptance, answer one cycle later
  always @(posedge ref_clk) begin
    fetch_ready <= ($random(seed) & 3) != 0;
    if (!data_valid || data_ready) begin
      data_valid <= mem_q.size() > 0;
      if (mem_q.size() > 0) begin
        data_byte <= mem_q.pop_front();
      end
    end
    if (fetch_valid && fetch_ready) begin
      mem_q.push_back(mem_val(fetch_req.addr));
    end
  end

  // Engine side monitor and hang limit
  always @(posedge ref_clk) begin
    cycles++;
    if (cmd_valid === 1'b1) begin
      n_valid++;
      last_rep = cmd_report;
    end
    n_abort += (cmd_abort === 1'b1);
    n_drive += (so_oe === 1'b1 || si_oe === 1'b1);
    if (cycles > 60000) begin
      err_total++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One frame and its expected bytes and report
  task automatic run(input logic [7:0] op, input logic [23:0] adr, input int nadr,
      input int ndum, input int nby, input bit dual, input logic [3:0] cls);
    int v0;
    int j;
    v0 = n_valid;
    host.frame(op, adr, nadr, ndum, nby > 0 ? nby * (dual ? 4 : 8) + 3 : 0, dual);
    check("byte count", host.rx_q.size(), nby);
    for (j = 0; j < nby && j < host.rx_q.size(); j++) begin
      check("read byte", host.rx_q[j], mem_val(15'(adr[14:0] + j)));
    end
    check("report count", n_valid - v0, 1);
    check("report class", last_rep.cls, cls);
    check("report opcode", last_rep.opcode, op);
    if (nadr == 3) begin
      check("report address", last_rep.addr, adr[14:0]);
    end
    check("lines released", {so_oe, si_oe}, 2'b00);
  endtask

  task automatic summarize();
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    resetn = 1'b0;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    run(8'h0b, 24'hab7ffe, 3, 1, 4, 1'b0, 4'h1);
    run(8'h3b, 24'h007fff, 3, 1, 2, 1'b1, 4'h2);
    // Random reads with the clock parked high between frames
    park_hi <= 1'b1;
    for (i = 0; i < 3; i++) begin
      run(8'h03, $random(seed), 3, 0, 3, 1'b0, 4'h1);
      run(8'h3b, $random(seed), 3, 1, 3, 1'b1, 4'h2);
    end
    park_hi <= 1'b0;
    for (i = 0; i < 18; i++) begin
      run(op_tab[i], $random(seed), (i < 4 || (i > 6 && i < 10)) ? 3 : 0,
        op_tab[i] == 8'h77 ? 2 : 0, 0, 1'b0, cls_tab[i]);
    end
    n_drive = 0;
    k = n_valid;
    host.frame(8'h5a, 24'h0b0000, 3, 1, 16, 1'b0);
    check("unknown report", n_valid - k, 0);
    k = n_abort;
    i = n_valid;
    host.frame(8'h0b, 24'h001234, 2, 0, 0, 1'b0);
    check("short frame abort", n_abort - k, 1);
    check("short frame report", n_valid - i, 0);
    check("no drive", n_drive, 0);
    run(8'h0b, $random(seed), 3, 1, 2, 1'b0, 4'h1);
    summarize();
  end
endmodule

bind sflash_front sflash_front_checker #(.ADDR_W(ADDR_W)) chk (.ref_clk(ref_clk),
  .resetn(resetn), .sck(sck), .cs_n(cs_n), .si_out(si_out), .si_oe(si_oe),
  .so_out(so_out), .so_oe(so_oe), .fetch_valid(fetch_valid), .fetch_req(fetch_req),
  .fetch_ready(fetch_ready), .cmd_valid(cmd_valid), .cmd_abort(cmd_abort));
